// File: src/rsdr_top.sv
// Receive sequencing, AGC, compound slicer and start-symbol data and clock recovery.
// Assumes a 10 MHz clock; slicer, enable and AGC inputs arrive asynchronously.
//
// Functional notes
// - By default the data output carries the combined slicer output directly.
// - With recovery enabled, data output switches to recovered data after start symbol.
// - Without recovery in use, the recovered bit clock stays low.
// - With recovery enabled, bit clock stays low until a start symbol is seen.
// - Each bit changes at bit clock rise; host samples at the following fall.
// - Once started, the bit clock keeps pulsing until the enable is cleared.
// - Combined slicer is threshold AND peak slicer; threshold slicer always active.
// - Open peak threshold pin disables the peak slicer; threshold slicer alone.
// - Amplifiers enabled alternately, 0.8 us (8 cycles) each, never both at once.
// - Saturation detect from the first amplifier selects 35 dB or 5 dB gain.
// - AGC reset comes from a comparator on the slicer input.
// - With recovery enabled, search the stream for 0xE2E2, MSB first.
// - Clocking begins mid-bit of the first bit after the start symbol.
`timescale 1ns/1ps
`include "rsdr_defs.svh"
module rsdr_top #(
  parameter int BIT_CYCLES = `RSDR_BIT_CYC,
  parameter int AMP_ON_CYCLES = `RSDR_AMP_ON_CYC,
  parameter int FIFO_DEPTH = `RSDR_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RSTN_I,
  // Analog front-end digital inputs
  input wire rsdr_pkg::rsdr_slicer_t SLICER_I,
  input wire logic SATURATION_DETECT_I,
  input wire logic SLICER_INPUT_AGC_RESET_I,
  // Host control
  input wire logic RECOVERY_ENABLE_I,
  // Amplifier control
  output rsdr_pkg::rsdr_amp_en_t AMP_EN_O,
  output logic GAIN_LOW_O,
  // Host data
  output logic RX_DATA_OUT_O,
  output logic RX_BIT_CLOCK_O
);
  import rsdr_pkg::*;

  localparam int PW = $clog2(BIT_CYCLES + 1);
  localparam int HALF = BIT_CYCLES / 2;
  localparam int AGW = $clog2(2 * AMP_ON_CYCLES + 1);

  if (BIT_CYCLES < 8 || AMP_ON_CYCLES < 1) begin : g_bad_params
    $error("rsdr_top: BIT_CYCLES must be at least 8 and AMP_ON_CYCLES at least 1");
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int NS = 6;
  logic [NS-1:0] sync1_r;
  logic [NS-1:0] sync2_r;

  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {SLICER_I.threshold_slicer, SLICER_I.peak_relative_slicer,
                  SLICER_I.peak_threshold_pin_open, SATURATION_DETECT_I,
                  SLICER_INPUT_AGC_RESET_I, RECOVERY_ENABLE_I};
      sync2_r <= sync1_r;
    end
  end

  logic thr_s;
  logic peak_s;
  logic open_s;
  logic sat_s;
  logic agc_rst_s;
  logic enable_s;
  logic combined;

  assign {thr_s, peak_s, open_s, sat_s, agc_rst_s, enable_s} = sync2_r;
  // The threshold slicer always takes part; the peak slicer only with its pin fitted.
  assign combined = thr_s && (peak_s || open_s);

  // ----------------------------------------------------------------
  // Amplifier pulse generator
  // ----------------------------------------------------------------
  logic [AGW-1:0] amp_ctr_r;

  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      amp_ctr_r <= '0;
    end else if (amp_ctr_r == AGW'(2 * AMP_ON_CYCLES - 1)) begin
      amp_ctr_r <= '0;
    end else begin
      amp_ctr_r <= amp_ctr_r + 1'b1;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      AMP_EN_O <= '0;
    end else begin
      AMP_EN_O.first_rf_amp <= (amp_ctr_r < AGW'(AMP_ON_CYCLES));
      AMP_EN_O.second_rf_amp <= (amp_ctr_r >= AGW'(AMP_ON_CYCLES));
    end
  end

  // ----------------------------------------------------------------
  // AGC control
  // ----------------------------------------------------------------
  // Saturation wins over reset so a strong burst is never met at full gain.
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      GAIN_LOW_O <= `RSDR_GAIN_RST;
    end else if (sat_s) begin
      GAIN_LOW_O <= 1'b1;
    end else if (agc_rst_s) begin
      GAIN_LOW_O <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Bit sampler and start symbol search
  // ----------------------------------------------------------------
  logic comb_d_r;
  logic [PW-1:0] phase_r;
  logic strobe;
  logic [`RSDR_SYM_BITS-1:0] shift_r;
  logic [`RSDR_SYM_BITS-1:0] shift_nxt;
  rsdr_state_t state_r;

  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      comb_d_r <= 1'b0;
      phase_r <= '0;
    end else begin
      comb_d_r <= combined;
      if (combined != comb_d_r || phase_r == PW'(BIT_CYCLES - 1)) begin
        phase_r <= '0;
      end else begin
        phase_r <= phase_r + 1'b1;
      end
    end
  end

  // Slicer edges re-centre the phase, so sampling lands mid-bit.
  assign strobe = (phase_r == PW'(HALF - 1));
  assign shift_nxt = {shift_r[`RSDR_SYM_BITS-2:0], combined};

  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      shift_r <= '0;
    end else if (state_r != RSDR_HUNT) begin
      shift_r <= '0;
    end else if (strobe) begin
      shift_r <= shift_nxt;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      state_r <= RSDR_IDLE;
    end else if (!enable_s) begin
      state_r <= RSDR_IDLE;
    end else begin
      unique case (state_r)
        RSDR_IDLE: state_r <= RSDR_HUNT;
        RSDR_HUNT: begin
          if (strobe && shift_nxt == `RSDR_START_SYMBOL) begin
            state_r <= RSDR_LOCK;
          end
        end
        RSDR_LOCK: state_r <= RSDR_LOCK;
        default: state_r <= RSDR_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Recovered bit buffer
  // ----------------------------------------------------------------
  logic push_valid_r;
  logic push_bit_r;
  logic push_ready;
  logic pop_valid;
  logic pop_ready;
  logic pop_bit;
  logic locked;

  assign locked = (state_r == RSDR_LOCK);

  // A bit waiting on a full buffer holds the sampler's push until room appears.
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      push_valid_r <= 1'b0;
      push_bit_r <= 1'b0;
    end else if (!locked) begin
      push_valid_r <= 1'b0;
    end else if (strobe) begin
      push_valid_r <= 1'b1;
      push_bit_r <= combined;
    end else if (push_ready) begin
      push_valid_r <= 1'b0;
    end
  end

  rsdr_fifo #(
    .WIDTH(1),
    .DEPTH(FIFO_DEPTH)
  ) rsdr_fifo_i (
    .clk_i(CLOCK_I),
    .rstn_i(RSTN_I),
    .flush_i(!locked),
    .in_valid_i(push_valid_r),
    .in_ready_o(push_ready),
    .in_data_i(push_bit_r),
    .out_valid_o(pop_valid),
    .out_ready_i(pop_ready),
    .out_data_o(pop_bit)
  );

  // ----------------------------------------------------------------
  // Bit clock generator and data output
  // ----------------------------------------------------------------
  logic [PW-1:0] half_ctr_r;

  assign pop_ready = locked && !RX_BIT_CLOCK_O && (half_ctr_r == '0);

  // The data pin moves on the same edge as the clock rise, so it is steady at the fall.
  // Once locked the pin keeps its last slicer value until the first recovered bit, then changes only to recovered bits, never on a slicer glitch.
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      RX_BIT_CLOCK_O <= 1'b0;
      RX_DATA_OUT_O <= 1'b0;
      half_ctr_r <= '0;
    end else if (!locked) begin
      RX_BIT_CLOCK_O <= 1'b0;
      RX_DATA_OUT_O <= combined;
      half_ctr_r <= '0;
    end else if (half_ctr_r != '0) begin
      half_ctr_r <= half_ctr_r - 1'b1;
    end else if (RX_BIT_CLOCK_O) begin
      RX_BIT_CLOCK_O <= 1'b0;
      half_ctr_r <= PW'(HALF - 1);
    end else if (pop_valid) begin
      RX_BIT_CLOCK_O <= 1'b1;
      RX_DATA_OUT_O <= pop_bit;
      half_ctr_r <= PW'(HALF - 1);
    end
  end

endmodule : rsdr_top

// File: src/rsdr_defs.svh
// Timing, start symbol and reset constants for the receive sequencing and recovery block.
// Assumes a 10 MHz system clock; included by bare name.
`ifndef RSDR_DEFS_SVH
`define RSDR_DEFS_SVH

// ----------------------------------------------------------------
// Clock and amplifier sequencing
// ----------------------------------------------------------------
`define RSDR_CLK_PERIOD_NS 100
`define RSDR_AMP_ON_NS 814
`define RSDR_AMP_ON_CYC (`RSDR_AMP_ON_NS / `RSDR_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Bit timing and start symbol
// ----------------------------------------------------------------
`define RSDR_BIT_NS 52080
`define RSDR_BIT_CYC (`RSDR_BIT_NS / `RSDR_CLK_PERIOD_NS)
`define RSDR_SYM_BITS 16
`define RSDR_START_SYMBOL 16'hE2E2

// ----------------------------------------------------------------
// Reset values and buffer depth
// ----------------------------------------------------------------
`define RSDR_GAIN_RST 1'h0
`define RSDR_FIFO_DEPTH 16

`endif

// File: src/rsdr_pkg.sv
// Types shared by the receive sequencing and recovery block.
// Assumes nothing beyond a SystemVerilog compiler.
package rsdr_pkg;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RSDR_IDLE = 2'h0,
    RSDR_HUNT = 2'h1,
    RSDR_LOCK = 2'h3
  } rsdr_state_t;

  typedef struct packed {
    logic threshold_slicer;
    logic peak_relative_slicer;
    logic peak_threshold_pin_open;
  } rsdr_slicer_t;

  typedef struct packed {
    logic first_rf_amp;
    logic second_rf_amp;
  } rsdr_amp_en_t;

endpackage : rsdr_pkg

// File: src/rsdr_fifo.sv
// Small FIFO with valid/ready on both sides and registered read data.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
module rsdr_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic flush_i,
  // Filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_params
    $error("rsdr_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW-1:0] rd_ptr_nxt;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  assign in_ready_o = (count_r != (AW+1)'(DEPTH));
  assign out_valid_o = (count_r != '0);
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign rd_ptr_nxt = pop ? rd_ptr_r + 1'b1 : rd_ptr_r;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_r] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else if (flush_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      rd_ptr_r <= rd_ptr_nxt;
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Head word is prefetched; a write into the slot about to be read bypasses memory.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_data_o <= '0;
    end else if (push && (wr_ptr_r == rd_ptr_nxt)) begin
      out_data_o <= in_data_i;
    end else begin
      out_data_o <= mem[rd_ptr_nxt];
    end
  end

endmodule : rsdr_fifo

// File: verif/rsdr_checker.sv
// Port assertions for the receive sequencing and recovery block.
// Assumes the bind hands on the BIT_CYCLES that the block was built with.
`timescale 1ns/1ps
module rsdr_checker #(
  parameter int BIT_CYCLES = 16
) (
  // Clock and reset
  input wire logic CLOCK_I,
  input wire logic RSTN_I,
  // Inputs
  input wire rsdr_pkg::rsdr_slicer_t SLICER_I,
  input wire logic SATURATION_DETECT_I,
  input wire logic SLICER_INPUT_AGC_RESET_I,
  input wire logic RECOVERY_ENABLE_I,
  // Outputs
  input wire rsdr_pkg::rsdr_amp_en_t AMP_EN_O,
  input wire logic GAIN_LOW_O,
  input wire logic RX_DATA_OUT_O,
  input wire logic RX_BIT_CLOCK_O
);
  import rsdr_pkg::*;
  localparam int RUN_MAX = BIT_CYCLES + 8;
  logic [1:0] up_r;
  logic [15:0] hi_r;
  logic comb_w;
  assign comb_w = SLICER_I.threshold_slicer &
    (SLICER_I.peak_relative_slicer | SLICER_I.peak_threshold_pin_open);
  // The age counter keeps $past from looking back into reset.
  always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      up_r <= 2'h0;
      hi_r <= 16'h0;
    end else begin
      up_r <= (up_r == 2'h3) ? up_r : up_r + 2'h1;
      hi_r <= RX_BIT_CLOCK_O ? hi_r + 16'h1 : 16'h0;
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RSTN_I);
  property p_amp_excl; !(AMP_EN_O.first_rf_amp && AMP_EN_O.second_rf_amp); endproperty
  a_amp_excl: assert property (p_amp_excl) else $error("amps both on");
  property p_amp_seq;
    $rose(AMP_EN_O.first_rf_amp) |-> AMP_EN_O.first_rf_amp[*8] ##1 AMP_EN_O.second_rf_amp;
  endproperty
  a_amp_seq: assert property (p_amp_seq) else $error("amp timing");
  property p_gain_set; SATURATION_DETECT_I[*4] |-> GAIN_LOW_O; endproperty
  a_gain_set: assert property (p_gain_set) else $error("gain not low");
  property p_gain_clr;
    (!SATURATION_DETECT_I && SLICER_INPUT_AGC_RESET_I)[*4] |-> !GAIN_LOW_O;
  endproperty
  a_gain_clr: assert property (p_gain_clr) else $error("gain not high");
  property p_clk_off; !RECOVERY_ENABLE_I[*5] |-> !RX_BIT_CLOCK_O; endproperty
  a_clk_off: assert property (p_clk_off) else $error("clock not low");
  // Two synchroniser stages and the output register put three edges between pin and pin.
  property p_data_pass;
    !RECOVERY_ENABLE_I[*5] ##0 up_r == 2'h3 |-> RX_DATA_OUT_O == $past(comb_w, 3);
  endproperty
  a_data_pass: assert property (p_data_pass) else $error("data not slicer");
  property p_clk_high; $fell(RX_BIT_CLOCK_O) |-> hi_r == 16'(BIT_CYCLES / 2); endproperty
  a_clk_high: assert property (p_clk_high) else $error("clock width");
  property p_data_hold; RX_BIT_CLOCK_O && $past(RX_BIT_CLOCK_O) |-> $stable(RX_DATA_OUT_O);
  endproperty
  a_data_hold: assert property (p_data_hold) else $error("data moved");
  property p_clk_run;
    $rose(RX_BIT_CLOCK_O) |-> ##[1:RUN_MAX] ($rose(RX_BIT_CLOCK_O) || !RECOVERY_ENABLE_I);
  endproperty
  a_clk_run: assert property (p_clk_run) else $error("clock stopped");
  c_lock: cover property ($rose(RX_BIT_CLOCK_O));
  c_gain: cover property ($rose(GAIN_LOW_O));
  c_stop: cover property ($fell(RECOVERY_ENABLE_I));
endmodule : rsdr_checker

bind rsdr_top rsdr_checker #(.BIT_CYCLES(BIT_CYCLES)) rsdr_checker_i (.CLOCK_I, .RSTN_I,
  .SLICER_I, .SATURATION_DETECT_I, .SLICER_INPUT_AGC_RESET_I, .RECOVERY_ENABLE_I,
  .AMP_EN_O, .GAIN_LOW_O, .RX_DATA_OUT_O, .RX_BIT_CLOCK_O);

// File: verif/rsdr_host.sv
// Host model: sets the recovery enable, reads bits on the clock fall.
// Assumes the bench pulses arm_i for one cycle to start a packet.
`timescale 1ns/1ps
module rsdr_host (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Bench and block side
  input wire logic arm_i,
  input wire logic data_i,
  input wire logic bclk_i,
  output logic en_o,
  output logic [7:0] got_o,
  output logic done_o
);
  logic [3:0] n_r;
  logic bclk_q;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      // The host comes up with recovery off and only turns it on once settled.
      en_o <= 1'h0;
      got_o <= 8'h0;
      n_r <= 4'h0;
      bclk_q <= 1'h0;
      done_o <= 1'h0;
    end else begin
      bclk_q <= bclk_i;
      if (arm_i && !en_o) begin
        en_o <= 1'h1;
        n_r <= 4'h0;
        done_o <= 1'h0;
      end else if (en_o && n_r == 4'h8) begin
        en_o <= 1'h0;
        done_o <= 1'h1;
      end else if (en_o && bclk_q && !bclk_i) begin
        got_o <= {got_o[6:0], data_i};
        n_r <= n_r + 4'h1;
      end
    end
  end
endmodule : rsdr_host

// File: verif/rsdr_top_test.sv
// Self-checking bench for the receive sequencing and recovery block.
// Assumes a shortened bit time; the host model owns the recovery enable.
`timescale 1ns/1ps
module rsdr_top_test;
  import rsdr_pkg::*;
  localparam int BITC = 16;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic sat = 1'h0;
  logic agc_rst = 1'h0;
  logic arm = 1'h0;
  logic bclk_q = 1'h0;
  rsdr_slicer_t slc = 3'h0;
  rsdr_amp_en_t amp;
  logic gain, rxd, bclk, en, done;
  logic [7:0] got;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  int n_rise = 0;
  rsdr_top #(.BIT_CYCLES(BITC)) rsdr_top_i (.CLOCK_I(clk), .RSTN_I(rstn), .SLICER_I(slc),
    .SATURATION_DETECT_I(sat), .SLICER_INPUT_AGC_RESET_I(agc_rst), .RECOVERY_ENABLE_I(en),
    .AMP_EN_O(amp), .GAIN_LOW_O(gain), .RX_DATA_OUT_O(rxd), .RX_BIT_CLOCK_O(bclk));
  rsdr_host rsdr_host_i (.clk_i(clk), .rstn_i(rstn), .arm_i(arm), .data_i(rxd),
    .bclk_i(bclk), .en_o(en), .got_o(got), .done_o(done));
  initial forever #50 clk = ~clk;
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tick(int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk
  // Bits go out MSB first on the threshold slicer, with the peak slicer held high and its pin fitted.
  task automatic send(logic [31:0] v, int n);
    for (int i = n - 1; i >= 0; i--) begin
      slc <= {v[i], 2'h2};
      tick(BITC);
    end
  endtask : send
  task automatic t_slicer;
    for (int i = 0; i < 8; i++) begin
      slc <= 3'(i);
      tick(4);
      chk("rx_data", 16'(rxd), 16'(i[2] & (i[1] | i[0])));
      chk("bit_clock", 16'(bclk), 16'h0);
    end
  endtask : t_slicer
  task automatic t_agc;
    sat <= 1'h1;
    tick(4);
    chk("gain_low", 16'(gain), 16'h1);
    sat <= 1'h0;
    agc_rst <= 1'h1;
    tick(4);
    chk("gain_high", 16'(gain), 16'h0);
    agc_rst <= 1'h0;
  endtask : t_agc
  task automatic t_amp;
    int n1 = 0;
    int n2 = 0;
    repeat (32) begin
      tick(1);
      n1 += amp.first_rf_amp;
      n2 += amp.second_rf_amp;
    end
    chk("amp_first_on", 16'(n1), 16'h10);
    chk("amp_second_on", 16'(n2), 16'h10);
  endtask : t_amp
  // A near-miss pattern runs ahead of the real start symbol.
  task automatic t_recover(logic [7:0] pay);
    arm <= 1'h1;
    tick(1);
    arm <= 1'h0;
    n_rise = 0;
    send(32'hE2E3E2E2, 32);
    chk("early_rise", 16'(n_rise), 16'h0);
    send(32'(pay), 8);
    send(32'h1, 2);
    for (int i = 0; i < 200 && done !== 1'h1; i++) tick(1);
    chk("done", 16'(done), 16'h1);
    chk("payload", 16'(got), 16'(pay));
    chk("pulses", 16'(n_rise), 16'h8);
    tick(5);
    chk("clock_off", 16'(bclk), 16'h0);
    slc <= 3'h6;
    tick(4);
    chk("data_back", 16'(rxd), 16'h1);
  endtask : t_recover
  always @(posedge clk) begin
    bclk_q <= bclk;
    if (bclk === 1'h1 && bclk_q === 1'h0) n_rise++;
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  initial begin
    tick(16);
    rstn <= 1'h1;
    tick(4);
    t_slicer();
    t_agc();
    t_amp();
    t_recover(8'hA5);
    t_recover(8'h3C);
    report_and_stop();
  end
endmodule : rsdr_top_test
